// file: logic/trace_word_mem.sv
// Purpose: Trace word storage with registered read data
// Assumes: One write and one read port on the core clock
// Notes:   Contents are undefined after reset
`timescale 1ns/1ns
module trace_word_mem
  import trace_pack_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                ce_i,
  input  wire logic                we_i,
  input  wire logic [AW-1:0]       waddr_i,
  input  wire logic [WORD_W-1:0]   wdata_i,
  input  wire logic [AW-1:0]       raddr_i,
  output logic      [WORD_W-1:0]   rdata_o
);
  logic [WORD_W-1:0] mem_ff [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
    begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      rdata_o <= mem_ff[raddr_i];
    end
  end
endmodule // trace_word_mem

// file: logic/trace_word_packer_ctrl.sv
// Purpose: Packs core trace messages into tagged 64-bit trace words
// Assumes: Core holds a message while stall is high; reads spaced 2 cycles
// Notes:   Serial probe shifting is outside; words leave on a ready/valid port
`timescale 1ns/1ns
module trace_word_packer_ctrl
  import trace_pack_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                ce_i,
  input  wire logic                trace_valid_i,
  input  wire logic [MSG_W-1:0]    trace_data_i,
  input  wire logic [LEN_W-1:0]    trace_len_i,
  input  wire logic [31:0]         data_addr_i,
  input  wire logic                trig_on_i,
  input  wire logic                trig_off_i,
  input  wire logic [15:0]         reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [31:0]         reg_wdata_i,
  output logic      [31:0]         reg_rdata_o,
  output logic                     core_stall_o,
  output logic                     sync_req_o,
  output logic      [6:0]          trace_mode_o,
  output logic                     port_clk_o,
  output logic                     port_valid_o,
  output logic      [WORD_W-1:0]   port_word_o,
  input  wire logic                port_ready_i
);
  import trace_pack_pkg::*;

  logic [CTL_W-1:0]   ctl_ff;
  logic [ACC_W-1:0]   acc_ff, nxt_acc;
  logic [CNT_W-1:0]   cnt_ff, nxt_cnt;
  logic [5:0]         first_ff, nxt_first;
  logic               first_vld_ff, nxt_first_vld;
  logic               wr_vld_ff;
  logic [WORD_W-1:0]  wr_word_ff;
  logic [AW-1:0]      wp_ff, rp_ff, prt_rp_ff;
  logic               wrap_ff, prt_ok_ff, inj_ff, ratio_ff;
  logic [AW:0]        fill_ff;
  logic [SYNC_W-1:0]  sync_ff;
  logic [1:0]         div_ff;
  logic [BM_LEN+DELTA_W-1:0] inj_msg_ff;
  pk_state_t          st_ff;
  logic [WORD_W-1:0]  mem_rdata;
  logic [ACC_W-1:0]   merged, fill_mask;
  logic [CNT_W-1:0]   total;
  logic [MSG_W-1:0]   msg;
  logic [LEN_W-1:0]   len;
  logic               accept, emit, illegal, full, port_mode, hit_lo, hit_hi;
  logic               sw_wp, ext_fdt, fdt_msg, flush_go;

  // Tag code for a start position
  function automatic logic [5:0] tag_enc(input logic [5:0] pos);
    case (pos)
      6'd0:    tag_enc = TAG_AT0;
      6'd16:   tag_enc = TAG_AT16;
      6'd32:   tag_enc = TAG_AT32;
      6'd48:   tag_enc = TAG_AT48;
      default: tag_enc = pos;
    endcase
  endfunction

  // Address match helper
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  // Mode and control decode
  // illegal mode mix
  assign illegal = (!ctl_ff[B_SPEC] && (|ctl_ff[B_FDT:B_CALL])) ||
                   (ctl_ff[B_FDT] && (ctl_ff[B_BMO] || (|ctl_ff[B_EXC:B_CALL]))) ||
                   (ctl_ff[B_BMO] && (|ctl_ff[B_EXC:B_CALL]));
  assign port_mode = ctl_ff[B_UNLOAD];
  assign full      = port_mode && (fill_ff[AW] == 1'b1);
  assign hit_lo    = hit(reg_addr_i, OFF_TW_LO);
  assign hit_hi    = hit(reg_addr_i, OFF_TW_HI);
  assign sw_wp     = reg_wr_i && hit(reg_addr_i, OFF_WR_PTR);
  assign fdt_msg   = trace_data_i[2:0] == FDT_CODE;
  assign ext_fdt   = ctl_ff[B_SPEC] && ctl_ff[B_FDT] && ctl_ff[B_XADDR];
  assign core_stall_o = (full && ctl_ff[B_STALL]) || inj_ff;
  assign accept    = trace_valid_i && !core_stall_o && ctl_ff[B_ON] && ctl_ff[B_EN] &&
                     !illegal && (st_ff == PK_RUN);
  assign flush_go  = (st_ff == PK_FLUSH);
  assign trace_mode_o = illegal ? 7'h00 : ctl_ff[B_XADDR:B_SPEC];

  // Message select, with zero delta for extended data trace
  // zero delta then match message
  always_comb
  begin
    msg = trace_data_i;
    len = trace_len_i;
    if (inj_ff)
    begin
      msg = MSG_W'(inj_msg_ff);
      len = ctl_ff[B_CYC] ? LEN_W'(BM_LEN + DELTA_W) : LEN_W'(BM_LEN);
    end
    else if (ext_fdt && fdt_msg && ctl_ff[B_CYC])
    begin
      msg[FDT_DLSB +: DELTA_W] = '0;
    end
  end

  // Ones above the fill level
  genvar gi;
  generate
    for (gi = 0; gi < ACC_W; gi++)
    begin : g_fill
      assign fill_mask[gi] = (gi >= int'(cnt_ff));
    end
  endgenerate

  // Packing datapath
  // append from LSB upward
  always_comb
  begin
    merged        = acc_ff;
    total         = cnt_ff;
    nxt_acc       = acc_ff;
    nxt_cnt       = cnt_ff;
    nxt_first     = first_ff;
    nxt_first_vld = first_vld_ff;
    emit          = 1'b0;
    if (accept || inj_ff)
    begin
      merged = acc_ff | (ACC_W'(msg) << cnt_ff);
      total  = cnt_ff + CNT_W'(len);
      if (!first_vld_ff)
      begin
        nxt_first     = cnt_ff[5:0];
        nxt_first_vld = 1'b1;
      end
      nxt_acc = merged;
      nxt_cnt = total;
      if (total >= CNT_W'(FIELD_W))
      begin
        emit          = 1'b1;
        nxt_acc       = merged >> FIELD_W;
        nxt_cnt       = total - CNT_W'(FIELD_W);
        nxt_first_vld = 1'b0;
      end
    end
    else if (flush_go && cnt_ff != '0)
    begin
      emit          = 1'b1;
      merged        = acc_ff | fill_mask;
      nxt_acc       = '0;
      nxt_cnt       = '0;
      nxt_first_vld = 1'b0;
    end
  end

  // Packer state
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_ff        <= PK_IDLE;
      acc_ff       <= '0;
      cnt_ff       <= '0;
      first_ff     <= '0;
      first_vld_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      acc_ff       <= nxt_acc;
      cnt_ff       <= nxt_cnt;
      first_ff     <= nxt_first;
      first_vld_ff <= nxt_first_vld;
      case (st_ff)
        PK_IDLE:  st_ff <= ctl_ff[B_ON] ? PK_RUN : PK_IDLE;
        PK_RUN:   st_ff <= ctl_ff[B_ON] ? PK_RUN : PK_FLUSH;
        PK_FLUSH: st_ff <= PK_IDLE;
        default:  st_ff <= PK_IDLE;
      endcase
    end
  end

  // Word register toward memory, tag in the low bits
  // encoded start in tag
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_vld_ff  <= 1'b0;
      wr_word_ff <= '0;
    end
    else if (ce_i)
    begin
      wr_vld_ff <= emit;
      if (emit)
      begin
        wr_word_ff <= {merged[FIELD_W-1:0],
                       tag_enc(first_vld_ff ? first_ff : cnt_ff[5:0])};
      end
    end
  end

  // Match message injection after an extended data message
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      inj_ff     <= 1'b0;
      inj_msg_ff <= '0;
    end
    else if (ce_i)
    begin
      inj_ff <= accept && ext_fdt && fdt_msg;
      if (accept && ext_fdt && fdt_msg)
      begin
        inj_msg_ff <= {{DELTA_W{1'b0}}, 1'b1, data_addr_i[31:1], 1'b0,
                       trace_data_i[6:3], BM_CODE};
      end
    end
  end

  // Write pointer and wrap flag
  // circular write
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp_ff   <= '0;
      wrap_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sw_wp)
      begin
        wp_ff   <= reg_wdata_i[PTR_W-1:3];
        wrap_ff <= 1'b0;
      end
      // Pointer moves only when the memory really takes the word
      if (wr_vld_ff && !full)
      begin
        wp_ff <= wp_ff + 1'b1;
        if (wp_ff == LAST_ADDR)
        begin
          wrap_ff <= 1'b1;
        end
      end
    end
  end

  // Read pointer, advanced by lower half reads
  // read advances and wraps
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rp_ff <= '0;
    end
    else if (ce_i)
    begin
      if (reg_wr_i && hit(reg_addr_i, OFF_RD_PTR))
      begin
        rp_ff <= reg_wdata_i[PTR_W-1:3];
      end
      else if (reg_rd_i && hit_lo)
      begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end

  // Control register with read-only and trigger driven bits
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctl_ff           <= '0;
      ctl_ff[B_UNLOAD] <= UNLOAD_PRESET;
    end
    else if (ce_i)
    begin
      if (reg_wr_i && hit(reg_addr_i, OFF_CTL))
      begin
        ctl_ff <= reg_wdata_i[CTL_W-1:0] & CTL_WMASK;
        if (!BOTH_MODES)
        begin
          ctl_ff[B_UNLOAD] <= UNLOAD_PRESET;
        end
      end
      else if (trig_on_i)
      begin
        ctl_ff[B_EN] <= 1'b1;
      end
      else if (trig_off_i)
      begin
        ctl_ff[B_EN] <= 1'b0;
      end
    end
  end

  // Register read data
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= '0;
    end
    else if (ce_i && reg_rd_i)
    begin
      case (1'b1)
        hit_lo:              reg_rdata_o <= mem_rdata[31:0];
        hit_hi:              reg_rdata_o <= mem_rdata[63:32];
        hit(reg_addr_i, OFF_RD_PTR): reg_rdata_o <= 32'({rp_ff, 3'b000});
        hit(reg_addr_i, OFF_WR_PTR): reg_rdata_o <= {wrap_ff, 31'({wp_ff, 3'b000})};
        hit(reg_addr_i, OFF_CTL):    reg_rdata_o <= {illegal, 15'h0000, ctl_ff};
        default:             reg_rdata_o <= '0;
      endcase
    end
  end

  // Sync period counter over accepted trace messages
  // sync every 2^(P+8)
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync_ff    <= '0;
      sync_req_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sync_req_o <= 1'b0;
      if (accept)
      begin
        if (sync_ff == SYNC_W'((32'h1 << (ctl_ff[8:B_SYP_LO] + SYNC_BASE)) - 1))
        begin
          sync_ff    <= '0;
          sync_req_o <= 1'b1;
        end
        else
        begin
          sync_ff <= sync_ff + 1'b1;
        end
      end
    end
  end

  // Off-chip unload: fill level and port pointer
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prt_rp_ff <= '0;
      fill_ff   <= '0;
      prt_ok_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      // skip a cycle after writing the word under the port pointer
      prt_ok_ff <= port_mode && !(port_valid_o && port_ready_i) &&
                   !(wr_vld_ff && !full && wp_ff == prt_rp_ff);
      if (!port_mode)
      begin
        prt_rp_ff <= wp_ff;
        fill_ff   <= '0;
      end
      else
      begin
        if (port_valid_o && port_ready_i)
        begin
          prt_rp_ff <= prt_rp_ff + 1'b1;
        end
        fill_ff <= fill_ff + (AW+1)'(wr_vld_ff && !full)
                           - (AW+1)'(port_valid_o && port_ready_i);
      end
    end
  end
  assign port_valid_o = port_mode && prt_ok_ff && (fill_ff != '0);
  assign port_word_o  = mem_rdata;

  // Port clock divider
  // half or quarter rate
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_ff     <= '0;
      ratio_ff   <= 1'b0;
      port_clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ratio_ff <= ctl_ff[B_RATIO];
      div_ff   <= div_ff + 1'b1;
      if (port_mode && (ratio_ff || div_ff[0]))
      begin
        port_clk_o <= !port_clk_o;
      end
    end
  end

  trace_word_mem u_mem (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (wr_vld_ff && !full),
    .waddr_i (wp_ff),
    .wdata_i (wr_word_ff),
    .raddr_i (port_mode ? prt_rp_ff : rp_ff),
    .rdata_o (mem_rdata)
  );

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i || !ce_i);

  sequence s_ext_accept;
    accept && ext_fdt && fdt_msg;
  endsequence
  sequence s_inject_once;
    inj_ff ##1 !inj_ff;
  endsequence

  tag_code_legal_a: assert property (wr_vld_ff |->
    !(wr_word_ff[5:0] inside {6'd0, 6'd16, 6'd32, 6'd48}) && wr_word_ff[5:0] < TAG_RSV)
    else $error("tag uses an unused or reserved code");
  tag_start_range_a: assert property (wr_vld_ff && wr_word_ff[5:0] < TAG_AT0 |->
    wr_word_ff[5:0] <= MAX_START)
    else $error("tag start beyond 56");
  field_emit_a: assert property (accept && !inj_ff && (cnt_ff + CNT_W'(len)) >= CNT_W'(FIELD_W) |=>
    wr_vld_ff && cnt_ff < CNT_W'(FIELD_W))
    else $error("full field not written");
  flush_fill_a: assert property (flush_go && cnt_ff != '0 && !accept && !inj_ff |=>
    wr_vld_ff && cnt_ff == '0)
    else $error("partial word not flushed");
  rp_advance_a: assert property (reg_rd_i && hit_lo && !reg_wr_i |=>
    rp_ff == $past(rp_ff) + 1'b1)
    else $error("read pointer did not advance");
  upper_hold_a: assert property (reg_rd_i && hit_hi && !reg_wr_i |=> $stable(rp_ff))
    else $error("upper read moved pointer");
  wrap_flag_set_a: assert property (wr_vld_ff && !full && wp_ff == LAST_ADDR |=>
    wrap_ff && wp_ff == '0)
    else $error("wrap flag not set");
  full_stall_a: assert property (full && ctl_ff[B_STALL] |-> core_stall_o && !accept)
    else $error("no stall while full");
  illegal_read_a: assert property (reg_rd_i && hit(reg_addr_i, OFF_CTL) |=>
    reg_rdata_o[B_ILLEGAL] == $past(illegal))
    else $error("illegal flag wrong");
  ext_inject_a: assert property (s_ext_accept |=> s_inject_once)
    else $error("match message not injected");
  port_clk_a: assert property (port_mode && ratio_ff |=>
    port_clk_o != $past(port_clk_o))
    else $error("port clock did not toggle");
endmodule // trace_word_packer_ctrl

// file: pkg/trace_pack_pkg.sv
// Purpose: Shared constants for the trace word packer and its memory
// Assumes: Register offsets are byte addresses on the debug segment
// Notes:   Memory depth and mode support are fixed here
package trace_pack_pkg;
  // Register offsets
  localparam logic [15:0] OFF_TW_LO    = 16'h3f80;
  localparam logic [15:0] OFF_TW_HI    = 16'h3f84;
  localparam logic [15:0] OFF_RD_PTR   = 16'h3f88;
  localparam logic [15:0] OFF_WR_PTR   = 16'h3f90;
  localparam logic [15:0] OFF_CTL      = 16'h3fc0;
  // Word layout
  localparam int FIELD_W  = 58;
  localparam int TAG_W    = 6;
  localparam int WORD_W   = 64;
  localparam int MSG_W    = 57;
  localparam int ACC_W    = FIELD_W + MSG_W;
  localparam int LEN_W    = 6;
  localparam int CNT_W    = 7;
  // Tag codes for the aligned start positions
  localparam logic [5:0] TAG_AT0  = 6'h3a;
  localparam logic [5:0] TAG_AT16 = 6'h3b;
  localparam logic [5:0] TAG_AT32 = 6'h3c;
  localparam logic [5:0] TAG_AT48 = 6'h3d;
  localparam logic [5:0] TAG_RSV  = 6'h3e;
  localparam logic [5:0] MAX_START = 6'h38;
  // Trace memory
  localparam int AW       = 8;
  localparam int PTR_W    = AW + 3;
  localparam logic [AW-1:0] LAST_ADDR = {AW{1'b1}};
  // Control register fields
  localparam int B_ILLEGAL = 31;
  localparam int B_XADDR   = 15;
  localparam int B_CYC     = 14;
  localparam int B_FDT     = 13;
  localparam int B_BMO     = 12;
  localparam int B_EXC     = 11;
  localparam int B_CALL    = 10;
  localparam int B_SPEC    = 9;
  localparam int B_SYP_LO  = 5;
  localparam int B_RATIO   = 4;
  localparam int B_UNLOAD  = 3;
  localparam int B_STALL   = 2;
  localparam int B_EN      = 1;
  localparam int B_ON      = 0;
  localparam int CTL_W     = 16;
  localparam logic [15:0] CTL_WMASK = 16'hffff;
  localparam logic        BOTH_MODES = 1'b1;
  localparam logic        UNLOAD_PRESET = 1'b0;
  // Sync period base exponent
  localparam int SYNC_BASE = 8;
  localparam int SYNC_W    = 24;
  // Breakpoint match message layout
  localparam int BM_LEN    = 39;
  localparam int DELTA_W   = 10;
  localparam int FDT_DLSB  = 47;
  localparam logic [2:0] FDT_CODE = 3'b011;
  localparam logic [1:0] BM_CODE  = 2'b01;
  // Packer states
  typedef enum logic [2:0] {
    PK_IDLE  = 3'b001,
    PK_RUN   = 3'b010,
    PK_FLUSH = 3'b100
  } pk_state_t;
endpackage

// file: test/core_trace_model.sv
// Purpose: Behavioural core side offering trace messages to the packer
// Assumes: A message is taken at an edge where stall was low
// Notes:   Released lines show the inverse of the last message
`timescale 1ns/1ns
module core_trace_model
(
  input  wire logic        clk_i,
  input  wire logic        stall_i,
  output logic             valid_o,
  output logic [56:0]      data_o,
  output logic [5:0]       len_o,
  output logic             hung_o
);
  logic stall_q;

  // Quiet lines at time zero
  initial
  begin
    valid_o = 1'b0;
    data_o = 57'h0;
    len_o = 6'h0;
    hung_o = 1'b0;
  end

  // Stall settled well before the next edge
  always @(negedge clk_i) stall_q <= stall_i;

  // Offer one message and hold it until taken
  task automatic send(input logic [56:0] data, input logic [5:0] len);
    int n;
    n = 0;
    #1;
    valid_o = 1'b1;
    data_o = data;
    len_o = len;
    @(posedge clk_i);
    while (stall_q === 1'b1 && n < 1000)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 1000) hung_o = 1'b1;
  endtask

  // Release and realign to the next edge
  task automatic idle();
    #1;
    valid_o = 1'b0;
    data_o = ~data_o;
    len_o = ~len_o;
    @(posedge clk_i);
  endtask
endmodule // core_trace_model

// file: test/trace_word_packer_ctrl_tb.sv
// Purpose: Self-checking bench for the trace word packer
// Assumes: Core model holds each message until taken
// Notes:   Register reads queue their expected value for the monitor
`timescale 1ns/1ns
module trace_word_packer_ctrl_tb;
  import trace_pack_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic              trig_on_i = 1'b0;
  logic              trig_off_i = 1'b0;
  logic [15:0]       reg_addr_i = 16'h0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [31:0]       reg_wdata_i = 32'h0;
  logic [31:0]       data_addr_i = 32'h0;
  logic              port_ready_i = 1'b0;
  logic [31:0]       reg_rdata_o;
  logic              core_stall_o, sync_req_o, port_clk_o, port_valid_o;
  logic [6:0]        trace_mode_o;
  logic [WORD_W-1:0] port_word_o;
  logic              valid, hung, rd_d;
  logic [MSG_W-1:0]  msg, data;
  logic [LEN_W-1:0]  len;
  logic [31:0]       exp_q[$];
  logic [255:0]      sbits = '1;
  logic [63:0]       w;
  logic [63:0]       pw;
  logic [63:0]       port_q[$];
  logic              pclk;
  logic [31:0]       addr_seen;
  logic [15:0]       modes [6] = '{16'h2000, 16'h2200, 16'h3200, 16'h1a00, 16'h0e00, 16'h1200};
  logic              bad [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  int                starts[$];
  int                nbits = 0;
  int                error_cnt = 0;
  int                total_checks = 0;
  int                sync_cnt = 0;
  integer            seed = 32'h9ac7580b;

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  trace_word_packer_ctrl uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .trace_valid_i(valid), .trace_data_i(data), .trace_len_i(len),
    .data_addr_i(data_addr_i), .trig_on_i(trig_on_i), .trig_off_i(trig_off_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .core_stall_o(core_stall_o),
    .sync_req_o(sync_req_o), .trace_mode_o(trace_mode_o), .port_clk_o(port_clk_o),
    .port_valid_o(port_valid_o), .port_word_o(port_word_o), .port_ready_i(port_ready_i));

  core_trace_model core (.clk_i(clk_i), .stall_i(core_stall_o), .valid_o(valid),
    .data_o(data), .len_o(len), .hung_o(hung));

  // Random port ready and address traffic
  always @(posedge clk_i)
  begin
    #1;
    port_ready_i = 1'($random(seed));
    data_addr_i = $random(seed);
  end

  // Read monitor and sync pulse counter
  always @(posedge clk_i) rd_d <= reg_rd_i;
  always @(posedge clk_i) if (sync_req_o === 1'b1) sync_cnt++;
  always @(negedge clk_i)
  begin
    if (rd_d === 1'b1 && exp_q.size() > 0)
      check(reg_rdata_o, exp_q.pop_front());
    else if (rd_d === 1'b1)
      check(32'h0, 32'hffff_ffff);
  end

  // Port monitor: a word leaves on valid and ready
  always @(negedge clk_i)
  begin
    if (port_valid_o === 1'b1 && port_ready_i === 1'b1 && port_q.size() > 0)
    begin
      pw = port_q.pop_front();
      check(port_word_o[63:32], pw[63:32]);
      check(port_word_o[31:0], pw[31:0]);
    end
    else if (port_valid_o === 1'b1 && port_ready_i === 1'b1)
      check(32'h0, 32'hffff_ffff);
  end

  // Hang guards
  always @(posedge clk_i)
  begin
    if (hung === 1'b1)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic reg_write(input logic [15:0] addr, input logic [31:0] val);
    #1;
    reg_addr_i = addr;
    reg_wdata_i = val;
    reg_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_i = 1'b0;
    reg_wdata_i = ~val;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic reg_read(input logic [15:0] addr, input logic [31:0] exp);
    #1;
    reg_addr_i = addr;
    reg_rd_i = 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_i);
    #1;
    reg_rd_i = 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic pulse(input logic on);
    #1;
    trig_on_i = on;
    trig_off_i = ~on;
    @(posedge clk_i);
    #1;
    trig_on_i = 1'b0;
    trig_off_i = 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Record a message into the expected stream, LSB first
  task automatic rec(input logic [56:0] m, input int n);
    starts.push_back(nbits);
    for (int i = 0; i < n; i++)
      sbits[nbits + i] = m[i];
    nbits += n;
  endtask

  // Offer a random message and record it
  task automatic push_msg(input logic [5:0] n);
    msg = 57'({$random(seed), $random(seed)}) & ((57'h1 << n) - 57'h1);
    rec(msg, n);
    core.send(msg, n);
  endtask

  // Expected word: field bits above a tag of the first start inside
  function automatic logic [63:0] word_exp(input int k);
    int pos;
    logic [5:0] tag;
    pos = -1;
    foreach (starts[i])
      if (pos < 0 && starts[i] >= 58 * k && starts[i] < 58 * k + 58)
        pos = starts[i] - 58 * k;
    tag = (pos == 0) ? 6'h3a : (pos == 16) ? 6'h3b : (pos == 32) ? 6'h3c :
          (pos == 48) ? 6'h3d : 6'(pos);
    return {sbits[58 * k +: 58], tag};
  endfunction

  initial
  begin
    repeat (16) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    @(posedge clk_i);
    reg_read(OFF_CTL, 32'h0);
    reg_read(16'h3f00, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      reg_write(OFF_CTL, 32'h7fff_0000 | 32'(modes[i]));
      reg_read(OFF_CTL, {bad[i], 15'h0, modes[i]});
      check({25'h0, trace_mode_o}, {25'h0, bad[i] ? 7'h0 : modes[i][15:9]});
    end
    reg_write(OFF_WR_PTR, 32'h0);
    reg_write(OFF_CTL, 32'h3);
    push_msg(6'd40);
    push_msg(6'd34);
    core.idle();
    pulse(1'b0);
    reg_read(OFF_CTL, 32'h1);
    pulse(1'b1);
    reg_read(OFF_CTL, 32'h3);
    push_msg(6'd57);
    push_msg(6'd50);
    push_msg(6'd20);
    core.idle();
    reg_write(OFF_CTL, 32'h2);
    reg_write(OFF_RD_PTR, 32'h0);
    // words read back upper half first
    for (int k = 0; k < 4; k++)
    begin
      w = word_exp(k);
      reg_read(OFF_TW_HI, w[63:32]);
      reg_read(OFF_TW_LO, w[31:0]);
    end
    reg_read(OFF_RD_PTR, 32'h20);
    reg_read(OFF_WR_PTR, 32'h20);
    reg_write(OFF_CTL, 32'h3);
    repeat (262)
      core.send(57'({$random(seed), $random(seed)}), 6'd57);
    core.idle();
    reg_read(OFF_WR_PTR, 32'h8000_0028);
    check(32'(sync_cnt), 32'h1);
    reg_write(OFF_WR_PTR, 32'h0);
    reg_read(OFF_WR_PTR, 32'h0);
    // Stop flushes the leftover bits as one more word
    reg_write(OFF_CTL, 32'h0);
    repeat (2) @(posedge clk_i);
    reg_read(OFF_WR_PTR, 32'h8);
    // Off-chip unload, half rate clock, extended data trace
    reg_write(OFF_CTL, 32'he21f);
    @(negedge clk_i) pclk = port_clk_o;
    @(negedge clk_i) check({31'h0, port_clk_o}, {31'h0, ~pclk});
    @(posedge clk_i);
    sbits = '1;
    starts.delete();
    nbits = 0;
    msg = 57'({$random(seed), $random(seed)});
    msg[2:0] = FDT_CODE;
    core.send(msg, 6'd57);
    addr_seen = data_addr_i;
    rec({10'h0, msg[46:0]}, 57);
    rec(57'({1'b1, addr_seen[31:1], 1'b0, msg[6:3], BM_CODE}), 49);
    port_q.push_back(word_exp(0));
    rec(57'h5, 10);
    core.send(57'h5, 6'd10);
    port_q.push_back(word_exp(1));
    core.idle();
    for (int n = 0; n < 200 && port_q.size() > 0; n++)
      @(posedge clk_i);
    check(32'(port_q.size()), 32'h0);
    close_out();
  end
endmodule // trace_word_packer_ctrl_tb
